// File: rtl/fcl_pkg.sv
// configuration loader constants, types and the shared field layouts
// assumes one 100 MHz core clock and a passive-mode link clock from outside
//
// How it works
// [RL1] start loading when config reset rises
// [RL2] fill config memory before enabling user mode
// [RL3] active mode clocks flash from own clock
// [RL4] first flash transaction is the wake instruction
// [RL5] wait at least 30 us after wake
// [RL6] fast read from address zero, stream bitstream
// [RL7] passive master supplies clock, control and data
// [RL8] widths: active 1/2/4, passive 1/2/4/8, jtag 1
// [RL9] optional load from on-chip mask store
// [RL10] opcodes, address msb first, dummy clocks
package fcl_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ       = 100;
    localparam int WAKE_WAIT_US  = 30;
    localparam int WAKE_WAIT_CYC = WAKE_WAIT_US * CLK_MHZ;

    // ------------------------------------------------------------------
    // flash command set and sequence lengths
    // ------------------------------------------------------------------
    localparam logic [7:0]  OP_WAKE      = 8'hAB;
    localparam logic [7:0]  OP_FAST_READ = 8'h0B;
    localparam logic [23:0] START_ADDR   = 24'h000000;
    localparam logic [5:0]  WAKE_BITS    = 6'h08;
    localparam logic [5:0]  CMD_BITS     = 6'h20;
    localparam logic [5:0]  DUMMY_CLKS   = 6'h08;

    // ------------------------------------------------------------------
    // reset values and widths
    // ------------------------------------------------------------------
    localparam int          CFG_AW     = 24;
    localparam logic [3:0]  RST_IO_OE  = 4'h0;
    localparam logic [7:0]  RST_BYTE   = 8'h00;

    typedef enum logic [1:0] {
        FCL_SRC_ACTIVE  = 2'b00,
        FCL_SRC_PASSIVE = 2'b01,
        FCL_SRC_JTAG    = 2'b10,
        FCL_SRC_MASK    = 2'b11
    } fcl_src_t;

    typedef enum logic [1:0] {
        FCL_W1 = 2'b00,
        FCL_W2 = 2'b01,
        FCL_W4 = 2'b10,
        FCL_W8 = 2'b11
    } fcl_width_t;

    typedef enum logic [3:0] {
        FCL_ST_IDLE  = 4'b0000,
        FCL_ST_WAKE  = 4'b0001,
        FCL_ST_GAP   = 4'b0010,
        FCL_ST_CMD   = 4'b0011,
        FCL_ST_DUMMY = 4'b0100,
        FCL_ST_DATA  = 4'b0101,
        FCL_ST_PASV  = 4'b0110,
        FCL_ST_JTAG  = 4'b0111,
        FCL_ST_MASK  = 4'b1000,
        FCL_ST_DONE  = 4'b1001
    } fcl_state_t;

    typedef struct packed {
        logic       sclk;
        logic       cs_n;
        logic [3:0] io_o;
        logic [3:0] io_oe;
    } fcl_spi_t;

    typedef struct packed {
        logic              we;
        logic [CFG_AW-1:0] addr;
        logic [7:0]        data;
    } fcl_cfg_wr_t;

endpackage

// File: rtl/fcl_loader.sv
// configuration loader: fills the config memory from flash, a passive
// master, jtag or the on-chip mask store, then raises config_done
// assumes straps are steady while config_reset_n rises; pins are async
module fcl_loader
    import fcl_pkg::*;
#(
    parameter int          BITSTREAM_BYTES = 1024,
    parameter int          SCLK_HALF       = 4,
    parameter bit          MASK_PRESENT    = 1'b0,
    parameter int          MASK_BYTES      = 16,
    parameter logic [127:0] MASK_IMAGE     = 128'h0
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        config_reset_n,
    input  wire logic [1:0]  strap_src,
    input  wire logic [1:0]  strap_width,
    output fcl_spi_t         spi,
    input  wire logic [3:0]  spi_io_i,
    input  wire logic        pas_clk,
    input  wire logic        pas_cs_n,
    input  wire logic [7:0]  pas_d,
    input  wire logic        jtag_tck,
    input  wire logic        jtag_tdi,
    output fcl_cfg_wr_t      config_memory,
    output logic             config_done
);

    // ------------------------------------------------------------------
    // pin synchronisers (core domain)
    // ------------------------------------------------------------------
    logic       crst_s1_q, crst_s2_q, crst_s3_q;
    logic [3:0] io_s1_q, io_s2_q;
    logic [1:0] jt_s1_q, jt_s2_q;
    logic       jt_tck_d3_q;
    logic       crst_rise, crst_low, jt_rise;

    // first stage flops feed only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crst_s1_q   <= 1'b0;
            crst_s2_q   <= 1'b0;
            crst_s3_q   <= 1'b0;
            io_s1_q     <= 4'h0;
            io_s2_q     <= 4'h0;
            jt_s1_q     <= 2'h0;
            jt_s2_q     <= 2'h0;
            jt_tck_d3_q <= 1'b0;
        end else begin
            crst_s1_q   <= config_reset_n;
            crst_s2_q   <= crst_s1_q;
            crst_s3_q   <= crst_s2_q;
            io_s1_q     <= spi_io_i;
            io_s2_q     <= io_s1_q;
            jt_s1_q     <= {jtag_tck, jtag_tdi};
            jt_s2_q     <= jt_s1_q;
            jt_tck_d3_q <= jt_s2_q[1];
        end
    end

    assign crst_rise = crst_s2_q & ~crst_s3_q;  // see [RL1]
    assign crst_low  = ~crst_s2_q;
    assign jt_rise   = jt_s2_q[1] & ~jt_tck_d3_q;

    // ------------------------------------------------------------------
    // strap capture and sequencer state
    // ------------------------------------------------------------------
    fcl_state_t state_q;
    fcl_src_t   src_q;
    fcl_width_t width_q;
    logic [1:0] wsel;

    // straps latched on the reset release edge, never under async reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            src_q   <= FCL_SRC_ACTIVE;
            width_q <= FCL_W1;
        end else if (crst_rise) begin
            src_q   <= fcl_src_t'(strap_src);
            width_q <= fcl_width_t'(strap_width);
        end
    end

    // active mode tops out at x4, jtag is always serial
    always_comb begin
        wsel = width_q;
        if (src_q == FCL_SRC_ACTIVE && width_q == FCL_W8) begin
            wsel = FCL_W4;  // see [RL8]
        end
        if (src_q == FCL_SRC_JTAG) begin
            wsel = FCL_W1;  // see [RL8]
        end
    end

    // ------------------------------------------------------------------
    // spi clock divider: flash clock made from our own clock
    // ------------------------------------------------------------------
    localparam int DW = $clog2(SCLK_HALF + 1);
    logic [DW-1:0] div_q;
    logic          sclk_q, spi_run, tick, rise, fall;

    assign spi_run = state_q == FCL_ST_WAKE || state_q == FCL_ST_CMD ||
                     state_q == FCL_ST_DUMMY || state_q == FCL_ST_DATA;
    assign tick    = spi_run && div_q == DW'(SCLK_HALF - 1);
    assign rise    = tick & ~sclk_q;
    assign fall    = tick & sclk_q;

    // clock idles low between frames so cs edges meet a quiet line
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q  <= '0;
            sclk_q <= 1'b0;
        end else if (!spi_run) begin
            div_q  <= '0;
            sclk_q <= 1'b0;
        end else begin
            div_q  <= tick ? '0 : div_q + DW'(1);
            sclk_q <= sclk_q ^ tick;  // see [RL3]
        end
    end

    // ------------------------------------------------------------------
    // shift register, bit counter and gap timer
    // ------------------------------------------------------------------
    localparam int WWC = $clog2(WAKE_WAIT_CYC + 1);
    logic [31:0]    sh_q;
    logic [5:0]     bits_q, beat_max;
    logic [WWC-1:0] wait_q;
    logic [7:0]     acc_q;
    logic [2:0]     beats_q;

    assign beat_max = 6'(8 >> wsel);

    // sequencer; a low config reset aborts any load in flight
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= FCL_ST_IDLE;
        end else if (crst_low) begin
            state_q <= FCL_ST_IDLE;  // see [RL1]
        end else begin
            case (state_q)
                FCL_ST_IDLE: begin
                    if (crst_rise) begin
                        case (fcl_src_t'(strap_src))
                            FCL_SRC_PASSIVE: state_q <= FCL_ST_PASV;
                            FCL_SRC_JTAG:    state_q <= FCL_ST_JTAG;
                            FCL_SRC_MASK: begin
                                state_q <= MASK_PRESENT ? FCL_ST_MASK
                                                        : FCL_ST_WAKE;
                            end
                            default:         state_q <= FCL_ST_WAKE;
                        endcase
                    end
                end
                FCL_ST_WAKE: begin
                    if (fall && bits_q == WAKE_BITS) begin
                        state_q <= FCL_ST_GAP;  // see [RL4]
                    end
                end
                FCL_ST_GAP: begin
                    if (wait_q == WWC'(WAKE_WAIT_CYC)) begin
                        state_q <= FCL_ST_CMD;  // see [RL5]
                    end
                end
                FCL_ST_CMD: begin
                    if (fall && bits_q == CMD_BITS) begin
                        state_q <= FCL_ST_DUMMY;
                    end
                end
                FCL_ST_DUMMY: begin
                    if (fall && bits_q == DUMMY_CLKS) begin
                        state_q <= FCL_ST_DATA;  // see [RL10]
                    end
                end
                FCL_ST_DATA, FCL_ST_PASV, FCL_ST_JTAG, FCL_ST_MASK: begin
                    if (config_memory.we &&
                        config_memory.addr == CFG_AW'(BITSTREAM_BYTES - 1)) begin
                        state_q <= FCL_ST_DONE;  // see [RL2]
                    end
                end
                FCL_ST_DONE:  state_q <= FCL_ST_DONE;
                default:      state_q <= FCL_ST_IDLE;
            endcase
        end
    end

    // command shifter: loaded on entry, advanced on falling clock edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_q <= '0;
        end else if (state_q == FCL_ST_IDLE && crst_rise) begin
            sh_q <= {OP_WAKE, 24'h000000};  // see [RL4]
        end else if (state_q == FCL_ST_GAP) begin
            sh_q <= {OP_FAST_READ, START_ADDR};  // see [RL6] [RL10]
        end else if (fall) begin
            sh_q <= {sh_q[30:0], 1'b0};
        end
    end

    // rising clocks counted per phase; gap timer counts with cs high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bits_q <= '0;
            wait_q <= '0;
        end else begin
            if (state_q == FCL_ST_GAP || state_q == FCL_ST_IDLE ||
                (fall && (bits_q == CMD_BITS || bits_q == WAKE_BITS &&
                 state_q != FCL_ST_CMD) && state_q != FCL_ST_DATA)) begin
                bits_q <= '0;
            end else if (rise) begin
                bits_q <= bits_q + 6'h01;
            end
            wait_q <= state_q == FCL_ST_GAP ? wait_q + WWC'(1) : '0;
        end
    end

    // ------------------------------------------------------------------
    // passive link domain: the master's clock captures its data beats
    // ------------------------------------------------------------------
    logic [1:0] pw_s1_q, pw_s2_q;
    logic [7:0] pas_acc_q, pas_byte_q;
    logic [2:0] pas_beats_q;
    logic       pas_tgl_q, pas_en_s1_q, pas_en_s2_q;
    logic [2:0] pas_max;

    assign pas_max = 3'((8 >> pw_s2_q) - 1);

    // width and enable arrive as levels from the core domain
    always_ff @(posedge pas_clk or negedge rst_n) begin
        if (!rst_n) begin
            pw_s1_q     <= 2'h0;
            pw_s2_q     <= 2'h0;
            pas_en_s1_q <= 1'b0;
            pas_en_s2_q <= 1'b0;
        end else begin
            pw_s1_q     <= width_q;
            pw_s2_q     <= pw_s1_q;
            pas_en_s1_q <= state_q == FCL_ST_PASV;
            pas_en_s2_q <= pas_en_s1_q;
        end
    end

    // a full byte is parked and announced by a toggle; the master must
    // leave one core handshake time between bytes, there is no buffer
    always_ff @(posedge pas_clk or negedge rst_n) begin
        if (!rst_n) begin
            pas_acc_q   <= RST_BYTE;
            pas_byte_q  <= RST_BYTE;
            pas_beats_q <= 3'h0;
            pas_tgl_q   <= 1'b0;
        end else if (!pas_en_s2_q || pas_cs_n) begin
            pas_beats_q <= 3'h0;  // see [RL7]
        end else begin
            case (pw_s2_q)
                FCL_W1:  pas_acc_q <= {pas_acc_q[6:0], pas_d[0]};
                FCL_W2:  pas_acc_q <= {pas_acc_q[5:0], pas_d[1:0]};
                FCL_W4:  pas_acc_q <= {pas_acc_q[3:0], pas_d[3:0]};
                default: pas_acc_q <= pas_d;  // see [RL8]
            endcase
            if (pas_beats_q == pas_max) begin
                pas_beats_q <= 3'h0;
                pas_tgl_q   <= ~pas_tgl_q;
                case (pw_s2_q)
                    FCL_W1:  pas_byte_q <= {pas_acc_q[6:0], pas_d[0]};
                    FCL_W2:  pas_byte_q <= {pas_acc_q[5:0], pas_d[1:0]};
                    FCL_W4:  pas_byte_q <= {pas_acc_q[3:0], pas_d[3:0]};
                    default: pas_byte_q <= pas_d;
                endcase
            end else begin
                pas_beats_q <= pas_beats_q + 3'h1;
            end
        end
    end

    // toggle brought home; parked byte is stable when the edge is seen
    logic pt_s1_q, pt_s2_q, pt_s3_q, pas_new;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pt_s1_q <= 1'b0;
            pt_s2_q <= 1'b0;
            pt_s3_q <= 1'b0;
        end else begin
            pt_s1_q <= pas_tgl_q;
            pt_s2_q <= pt_s1_q;
            pt_s3_q <= pt_s2_q;
        end
    end
    assign pas_new = pt_s2_q ^ pt_s3_q;

    // ------------------------------------------------------------------
    // on-chip mask store, one byte per entry
    // ------------------------------------------------------------------
    logic [7:0] mask_rom [MASK_BYTES];
    logic [CFG_AW-1:0] mask_ptr_q;

    for (genvar i = 0; i < MASK_BYTES; i++) begin : g_rom
        assign mask_rom[i] = MASK_IMAGE[8*i +: 8];  // see [RL9]
    end

    // the image repeats if the stream is longer than the store
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_ptr_q <= '0;
        end else if (state_q != FCL_ST_MASK) begin
            mask_ptr_q <= '0;
        end else begin
            mask_ptr_q <= mask_ptr_q + CFG_AW'(1);
        end
    end

    // ------------------------------------------------------------------
    // byte assembly for flash and jtag, and the config memory port
    // ------------------------------------------------------------------
    logic       byte_v;
    logic [7:0] byte_d, acc_d;
    logic [3:0] flash_bits;

    assign flash_bits = wsel == FCL_W1 ? {3'h0, io_s2_q[1]} : io_s2_q;

    always_comb begin
        case (wsel)
            FCL_W1:  acc_d = {acc_q[6:0], flash_bits[0]};
            FCL_W2:  acc_d = {acc_q[5:0], flash_bits[1:0]};
            default: acc_d = {acc_q[3:0], flash_bits};
        endcase
        if (state_q == FCL_ST_JTAG) begin
            acc_d = {acc_q[6:0], jt_s2_q[0]};  // see [RL8]
        end
    end

    // flash data sampled on our falling edge, one full clock after launch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q   <= RST_BYTE;
            beats_q <= 3'h0;
        end else if ((state_q == FCL_ST_DATA && fall) ||
                     (state_q == FCL_ST_JTAG && jt_rise)) begin
            acc_q   <= acc_d;  // see [RL6]
            beats_q <= beats_q + 3'h1 == 3'(beat_max) ? 3'h0
                                                       : beats_q + 3'h1;
        end else if (state_q == FCL_ST_IDLE) begin
            beats_q <= 3'h0;
        end
    end

    always_comb begin
        byte_v = 1'b0;
        byte_d = acc_d;
        case (state_q)
            FCL_ST_DATA: byte_v = fall && beats_q + 3'h1 == 3'(beat_max);
            FCL_ST_JTAG: byte_v = jt_rise && beats_q == 3'h7;
            FCL_ST_PASV: begin
                byte_v = pas_new;
                byte_d = pas_byte_q;
            end
            FCL_ST_MASK: begin
                byte_v = mask_ptr_q < CFG_AW'(BITSTREAM_BYTES);  // see [RL2]
                byte_d = mask_rom[mask_ptr_q % MASK_BYTES];
            end
            default:     byte_v = 1'b0;
        endcase
    end

    // config memory written sequentially from address zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            config_memory <= '0;
        end else begin
            config_memory.we   <= byte_v && state_q != FCL_ST_DONE;
            config_memory.data <= byte_v ? byte_d : config_memory.data;
            if (state_q == FCL_ST_IDLE) begin
                config_memory.addr <= '0;
            end else if (config_memory.we) begin
                config_memory.addr <= config_memory.addr + CFG_AW'(1);
            end
        end
    end

    // user logic released only once the last byte has landed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            config_done <= 1'b0;
        end else begin
            config_done <= state_q == FCL_ST_DONE && !crst_low;  // see [RL2]
        end
    end

    // ------------------------------------------------------------------
    // flash pins: only io0 driven, as command line, while commands go out
    // ------------------------------------------------------------------
    logic       cs_n_q;
    logic [3:0] io_oe_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_n_q  <= 1'b1;
            io_oe_q <= RST_IO_OE;
        end else begin
            cs_n_q  <= !spi_run;  // see [RL5]
            io_oe_q <= (state_q == FCL_ST_WAKE || state_q == FCL_ST_CMD)
                       ? 4'h1 : RST_IO_OE;
        end
    end
    assign spi = '{sclk: sclk_q, cs_n: cs_n_q, io_o: {3'h0, sh_q[31]},
                   io_oe: io_oe_q};  // see [RL3] [RL10]

endmodule

// File: dv/fcl_properties.sv
// checker: pin timing of the loader's flash link and write port
// assumes it is bound into fcl_loader with SCLK_HALF left at 4
module fcl_properties
    import fcl_pkg::*;
#(
    parameter int BITSTREAM_BYTES = 8
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        config_reset_n,
    input wire logic [1:0]  strap_src,
    input wire fcl_spi_t    spi,
    input wire fcl_cfg_wr_t config_memory,
    input wire logic        config_done
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0] rise_q;  // flash clock rises in the open frame
    logic       woke_q;  // wake frame already closed in this load

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // rise count restarts whenever select is high
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) rise_q <= '0;
        else if (spi.cs_n) rise_q <= '0;
        else if ($rose(spi.sclk)) rise_q <= rise_q + 6'h01;

    // cleared by config reset so an aborted wake is not taken as closed
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) woke_q <= 1'b0;
        else if (!config_reset_n) woke_q <= 1'b0;
        else if ($rose(spi.cs_n)) woke_q <= 1'b1;

    sequence s_load_start;
        $rose(config_reset_n) && strap_src == FCL_SRC_ACTIVE;
    endsequence
    sequence s_wake_end;
        $rose(spi.cs_n) && !woke_q && config_reset_n;
    endsequence

    a_start_wake:
    assert property (s_load_start |-> ##[2:10] $fell(spi.cs_n))
        else $error("load start opened no flash frame");
    a_wake_length:
    assert property (s_wake_end |-> rise_q == WAKE_BITS)
        else $error("wake frame clock count wrong");
    // a pulse cut short by config reset is a legal abort
    a_sclk_shape:
    assert property (disable iff (!rst_n || !config_reset_n)
        $rose(spi.sclk) |-> (!spi.cs_n && spi.sclk) [*4] ##1 !spi.sclk)
        else $error("flash clock pulse malformed");
    a_io_single:
    assert property (spi.io_oe inside {4'h0, 4'h1} && spi.io_o[3:1] == 3'h0)
        else $error("command drove more than one line");
    a_abort_idle:
    assert property (!config_reset_n [*6] |-> spi.cs_n && !config_done)
        else $error("config reset low did not idle the loader");
    a_done_cause:
    assert property ($rose(config_done) |-> $past(config_memory.we, 2) &&
        $past(config_memory.addr, 2) == 24'(BITSTREAM_BYTES - 1))
        else $error("done rose without the last write");
    a_done_quiet:
    assert property (config_done |-> !config_memory.we)
        else $error("write after done");
    a_addr_step:
    assert property (config_memory.we |=>
        config_memory.addr == $past(config_memory.addr) + 24'h000001)
        else $error("write address did not step");
endmodule

bind fcl_loader fcl_properties #(
    .BITSTREAM_BYTES(BITSTREAM_BYTES)
) u_props (.clk, .rst_n, .config_reset_n, .strap_src, .spi,
    .config_memory, .config_done);

// File: dv/fcl_flash_model.sv
// behavioural serial flash: wake, fast read and a fixed byte stream
// assumes mode 0: takes bits on clock rise, moves data on clock fall
module fcl_flash_model
    import fcl_pkg::*;
(
    input  wire logic       rst_n,
    input  wire fcl_spi_t   spi,
    input  wire logic [1:0] width,
    output logic [3:0]      io,
    output logic [7:0]      wake_op,
    output int              wake_bits,
    output logic [31:0]     cmd_word,
    output int              gap_ns
);
    timeunit 1ns;
    timeprecision 100ps;
    int          nfr;
    int          rise;
    int          beat;
    int          p;
    logic [31:0] sh;
    logic [7:0]  v;
    realtime     t_end;

    initial io = 4'h5;
    // frame open: restart counts, time the wake gap
    always @(negedge spi.cs_n) begin
        rise = 0;
        beat = 0;
        if (nfr == 1) gap_ns = int'($realtime - t_end);
    end
    // frame close: lines released, so show the inverse of the last level
    always @(posedge spi.cs_n or negedge rst_n) begin
        io = ~io;
        if (!rst_n) nfr = 0;
        else begin
            if (nfr == 0) begin
                wake_op = sh[7:0];
                wake_bits = rise;
                t_end = $realtime;
            end
            nfr++;
        end
    end
    // command and address bits taken on the rising edge
    always @(posedge spi.sclk) begin
        if (!spi.cs_n) begin
            sh = {sh[30:0], spi.io_o[0]};
            rise++;
            if (nfr == 1 && rise == 32) cmd_word = sh;
        end
    end
    // after 8 dummy clocks each fall moves one beat, msb beat first
    always @(negedge spi.sclk) begin
        if (!spi.cs_n && nfr == 1 && rise >= 40) begin
            p = beat << width;
            v = 8'((p / 8) * 37) ^ 8'hC3;
            v = v >> (8 - p % 8 - (1 << width));
            io = width == 2'b00 ? {2'b00, v[0], 1'b0} : v[3:0];
            beat++;
        end
    end
endmodule

// File: dv/fpga_config_loader_bench.sv
// self-checking bench: every load source and width, byte by byte
// assumes the loader, the flash model and the bound checker in scope
module fpga_config_loader_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import fcl_pkg::*;
    localparam int NB = 8;
    localparam logic [127:0] IMG = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        config_reset_n = 1'b0;
    logic [1:0]  strap_src = 2'b00;
    logic [1:0]  strap_width = 2'b00;
    logic        pas_clk = 1'b0;
    logic        pas_cs_n = 1'b1;
    logic [7:0]  pas_d = 8'h00;
    logic        jtag_tck = 1'b0;
    logic        jtag_tdi = 1'b0;
    logic [3:0]  spi_io_i;
    logic [7:0]  wake_op;
    logic [31:0] cmd_word;
    logic        config_done;
    fcl_spi_t    spi;
    fcl_cfg_wr_t config_memory;
    int          wake_bits;
    int          gap_ns;
    int          failures = 0;
    int          samples_checked = 0;

    always #5 clk = ~clk;
    fcl_loader #(.BITSTREAM_BYTES(NB), .MASK_PRESENT(1'b1),
        .MASK_IMAGE(IMG)) uut (.clk, .rst_n, .config_reset_n,
        .strap_src, .strap_width, .spi, .spi_io_i, .pas_clk, .pas_cs_n,
        .pas_d, .jtag_tck, .jtag_tdi, .config_memory, .config_done);
    fcl_flash_model flash (.rst_n(config_reset_n), .spi,
        .width(strap_width == 2'b11 ? 2'b10 : strap_width), // quad flash
        .io(spi_io_i), .wake_op, .wake_bits,
        .cmd_word, .gap_ns);

    function automatic logic [7:0] pat(input int i);
        return 8'(i * 37) ^ 8'hC3;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // config reset held low 8 cycles, straps steady across the rise
    task automatic load(input logic [1:0] s, w);
        @(posedge clk);
        #1 config_reset_n = 1'b0;
        strap_src = s;
        strap_width = w;
        repeat (8) @(posedge clk);
        #1 config_reset_n = 1'b1;
    endtask
    // waits for each write pulse, then checks done three cycles after the last
    task automatic collect(input logic m);
        int t;
        logic [7:0] e;
        for (int i = 0; i < NB; i++) begin
            t = 0;
            do begin
                @(posedge clk);
                #1 t++;
            end while (config_memory.we !== 1'b1 && t < 9000);
            e = m ? IMG[8 * i +: 8] : pat(i);
            check("we", config_memory.we, 1);
            check("addr", config_memory.addr, i);
            check("data", config_memory.data, e);
            check("early done", config_done, 0);
        end
        repeat (3) @(posedge clk);
        #1 check("done", config_done, 1);
        check("writes", config_memory.addr, NB);
    endtask
    task automatic t_active(input logic [1:0] w);
        load(FCL_SRC_ACTIVE, w);
        collect(1'b0);
        check("wake op", wake_op, OP_WAKE);
        check("wake bits", wake_bits, 8);
        check("read cmd", cmd_word, {OP_FAST_READ, 24'h000000});
        check("gap", gap_ns >= 30000, 1);
        $display("active x%0d finished", 1 << w);
    endtask
    // link clock runs at 12 ns only while pulse is called, inside a frame or not
    task automatic pulse(input int n);
        repeat (n) begin
            #6 pas_clk = 1'b1;
            #6 pas_clk = 1'b0;
        end
    endtask
    task automatic t_passive(input logic [1:0] w);
        load(FCL_SRC_PASSIVE, w);
        repeat (10) @(posedge clk);
        pulse(4); // unselected beats, ignored
        fork
            collect(1'b0);
            for (int i = 0; i < NB; i++) begin
                pas_cs_n = 1'b0;
                for (int k = 0; k < (8 >> w); k++) begin
                    pas_d = pat(i) >> (8 - ((k + 1) << w));
                    pulse(1);
                end
                pas_cs_n = 1'b1;
                pas_d = ~pas_d;
                #60; // byte spacing above 50 ns, there is no buffer
            end
        join
        $display("passive x%0d finished", 1 << w);
    endtask
    task automatic t_jtag();
        logic [7:0] b;
        load(FCL_SRC_JTAG, 2'b00);
        for (int i = 0; i < 8 * NB; i++) begin
            b = pat(i / 8);
            fork
                if (i == 0) collect(1'b0);
            join_none
            repeat (4) @(posedge clk);
            #1 jtag_tdi = b[7 - i % 8];
            jtag_tck = 1'b0;
            repeat (4) @(posedge clk);
            #1 jtag_tck = 1'b1;
        end
        wait fork;
        jtag_tck = 1'b0;
        $display("jtag finished");
    endtask
    task automatic t_mask();
        load(FCL_SRC_MASK, 2'b00);
        collect(1'b1);
        $display("mask store finished");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        for (int w = 0; w < 4; w++) t_active(2'(w));
        for (int w = 0; w < 4; w++) t_passive(2'(w));
        t_jtag();
        t_mask();
        wrap_up();
    end
    // about 16k cycles expected; a hang is cut at 50k
    initial begin
        #500us;
        failures++;
        wrap_up();
    end
endmodule
